// ===== src/oss_defs.vh
/*
 * Constants for the oscillator source select block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes a 40 MHz APB clock on pclk and an includer that uses
 * plain Verilog-2005.
 */
// Overview of operation
// RULE1: Select field picks system clock source; changeable while running.
// RULE2: Low speed select bit picks slow RC or watch crystal.
// RULE3: Fast RC runs at 2, 4 or 8 MHz set by factory option.
// RULE4: Software sets fast RC frequency field equal to factory option.
// RULE5: Watch crystal starts on enable write of 1; usable after start-up.
// RULE6: Speed-up bit 0 gives low power mode, 1 gives speed-up mode.
// RULE7: Speed-up stabilises fast; clearing it later keeps oscillator running.
// RULE8: Mode frozen, speed-up writes ignored while crystal clocks system.
// RULE9: Crystal works in both modes; low power start-up is longer.
// RULE10: Software sets crystal mode before choosing it as system clock.
// RULE11: Pin-sharing bits route crystal pins to oscillator or general I/O.
// RULE12: Oscillators also clock watchdog and time base logic.
// RULE13: Watch crystal is a fixed 32.768 kHz clock downstream.
// RULE14: Slow RC is the other low speed source, nominal 32 kHz.
// RULE15: High speed sources are fast RC and external fast crystal.
// RULE16: Software always configures one high and one low speed source.
// RULE17: System clock stops in sleep or idle; independent clock runs.
// RULE18: Fast source select bit picks external crystal or fast RC.
// RULE19: High speed source divided by 1 to 64 per select field.
// RULE20: Source and ratio switching is glitch-free, no runt pulses.
`ifndef OSS_DEFS_VH
`define OSS_DEFS_VH

// =====================================================================
// Register map (byte addresses)
`define OSS_ADDR_CLK_CTRL   12'h000
`define OSS_ADDR_FRC_CTRL   12'h004
`define OSS_ADDR_WXT_CTRL   12'h008
`define OSS_ADDR_PIN_CTRL   12'h00c
`define OSS_ADDR_STATUS     12'h010

// =====================================================================
// Clock control register fields
`define OSS_CC_SEL_HI       7
`define OSS_CC_SEL_LO       5
`define OSS_CC_FHS          3
`define OSS_CC_FSS          2
`define OSS_CC_FHIDEN       1
`define OSS_CC_FSIDEN       0
`define OSS_SEL_SLOW        3'h7

// Fast RC control fields
`define OSS_FR_FREQ_HI      3
`define OSS_FR_FREQ_LO      2
`define OSS_FR_EN           0

// Watch crystal control fields
`define OSS_WX_SPEEDUP      2
`define OSS_WX_READY        1
`define OSS_WX_EN           0

// Pin control field
`define OSS_PIN_XTAL        0

// Status fields
`define OSS_ST_SYS_SLOW     0
`define OSS_ST_FRC_MATCH    1
`define OSS_ST_WXT_LOCK     2
`define OSS_ST_SYS_RUN      3
`define OSS_ST_DIV_LO       4

// Reset values
`define OSS_RST_CLK_CTRL    8'h00
`define OSS_RST_FRC_CTRL    4'h1
`define OSS_RST_WXT_CTRL    3'h0

// =====================================================================
// Start-up delays counted in slow clock ticks
`define OSS_WXT_START_FAST  16'h0400
`define OSS_WXT_START_LOWP  16'h1000

`endif

// ===== src/oss_sync.v
/*
 * Two-flop level synchroniser.
 * Assumes the input is a level from another domain.
 */
module oss_sync (
    input  wire clk,
    input  wire rst_n,
    input  wire d,
    output reg  q
);
    reg meta_q;

    // =================================================================
    // Synchroniser
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // oss_sync

// ===== src/oss_clk_mux.v
/*
 * Glitch-free two-input clock enable switch.
 * Assumes the two enables come from the same clock domain.
 */
module oss_clk_mux (
    input  wire clk,
    input  wire rst_n,
    input  wire sel,
    input  wire en_a,
    input  wire en_b,
    output reg  en_out,
    output reg  sel_q
);
    reg pend_q;

    // =================================================================
    // Switch only on a cycle where neither enable fires
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q  <= 1'b0;
            pend_q <= 1'b0;
            en_out <= 1'b0;
        end else begin
            pend_q <= (sel != sel_q);
            if (pend_q && (sel != sel_q) && !en_a && !en_b) begin
                sel_q <= sel; // [RULE20]
            end
            en_out <= sel_q ? en_b : en_a;
        end
    end
endmodule // oss_clk_mux

// ===== src/oss_top.v
/*
 * Oscillator source and system clock select logic with APB registers.
 * Oscillators arrive as sampled pins; the system clock leaves as a
 * one-cycle enable on pclk. Assumes pclk at 40 MHz, far above fast
 * oscillator pin rates, and a factory option strap that is static.
 */
`include "oss_defs.vh"

module oss_top #(
    parameter START_FAST = `OSS_WXT_START_FAST,
    parameter START_LOWP = `OSS_WXT_START_LOWP
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        frc_osc,
    input  wire        fxt_osc,
    input  wire        src_osc,
    input  wire        wxt_osc,
    input  wire [1:0]  frc_option,
    input  wire        cpu_halt,
    output reg         sys_clk_en,
    output reg         wdt_clk_en,
    output reg         tbase_clk_en,
    output reg         wxt_osc_enable,
    output reg         wxt_osc_speedup,
    output reg         wxt_pins_osc,
    output reg         fast_osc_enable
);

    // =================================================================
    // Registers
    reg [7:0]  clock_ctrl_reg_q;
    reg [3:0]  fast_rc_ctrl_reg_q;
    reg [2:0]  wxt_ctrl_q;
    reg        pin_ctrl_q;
    reg [15:0] wxt_cnt_q;
    reg        wxt_ready_q;
    reg [5:0]  div_cnt_q;
    reg        frc_d1_q, fxt_d1_q, src_d1_q, wxt_d1_q;
    reg        hs_tick, ls_tick, src_tick, wxt_tick;
    reg        div_tick;
    reg        frc_match_q;

    wire       frc_s, fxt_s, src_s, wxt_s;
    wire       hs_en, sys_en_mux, sel_slow_q;
    wire [2:0] sysclk_select_field;
    wire       low_speed_source_select;
    wire       fast_source_select;
    wire       wxt_is_sys;
    wire       apb_wr;
    wire       apb_rd;
    reg  [5:0] div_mask;

    assign sysclk_select_field =
        clock_ctrl_reg_q[`OSS_CC_SEL_HI:`OSS_CC_SEL_LO];
    assign low_speed_source_select = clock_ctrl_reg_q[`OSS_CC_FSS];
    assign fast_source_select      = clock_ctrl_reg_q[`OSS_CC_FHS];
    assign wxt_is_sys = (sysclk_select_field == `OSS_SEL_SLOW) &&
                        low_speed_source_select; // [RULE8] [RULE10]
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !pwrite;

    // =================================================================
    // Pin synchronisers; edge detect on the second flop only
    oss_sync u_sync_frc (.clk(pclk), .rst_n(presetn), .d(frc_osc),
                         .q(frc_s));
    oss_sync u_sync_fxt (.clk(pclk), .rst_n(presetn), .d(fxt_osc),
                         .q(fxt_s));
    oss_sync u_sync_src (.clk(pclk), .rst_n(presetn), .d(src_osc),
                         .q(src_s));
    oss_sync u_sync_wxt (.clk(pclk), .rst_n(presetn), .d(wxt_osc),
                         .q(wxt_s));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frc_d1_q <= 1'b0;
            fxt_d1_q <= 1'b0;
            src_d1_q <= 1'b0;
            wxt_d1_q <= 1'b0;
        end else begin
            frc_d1_q <= frc_s;
            fxt_d1_q <= fxt_s;
            src_d1_q <= src_s;
            wxt_d1_q <= wxt_s;
        end
    end

    // =================================================================
    // Source ticks
    always @* begin
        src_tick = src_s && !src_d1_q; // [RULE14]
        // Crystal clock gated until start-up has elapsed
        wxt_tick = wxt_s && !wxt_d1_q && wxt_ready_q &&
                   wxt_ctrl_q[`OSS_WX_EN] && pin_ctrl_q; // [RULE13]
        hs_tick  = fast_source_select ?
                   (fxt_s && !fxt_d1_q) :
                   (frc_s && !frc_d1_q &&
                    fast_rc_ctrl_reg_q[`OSS_FR_EN]); // [RULE15] [RULE18]
        ls_tick  = low_speed_source_select ? wxt_tick
                                           : src_tick; // [RULE2]
    end

    // =================================================================
    // Divider 1..64; ratio 2^field for fields 0..6
    always @* begin
        case (sysclk_select_field)
            3'h0:    div_mask = 6'h00;
            3'h1:    div_mask = 6'h01;
            3'h2:    div_mask = 6'h03;
            3'h3:    div_mask = 6'h07;
            3'h4:    div_mask = 6'h0f;
            3'h5:    div_mask = 6'h1f;
            default: div_mask = 6'h3f;
        endcase
        // Ratio change takes effect on the next high speed tick, even mid-period
        // [RULE19] [RULE20]
        div_tick = hs_tick && ((div_cnt_q & div_mask) == 6'h00);
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 6'h00;
        end else if (hs_tick) begin
            div_cnt_q <= div_cnt_q - 6'h01;
        end
    end
    assign hs_en = div_tick;

    // =================================================================
    // Source switch between divided high speed and low speed
    oss_clk_mux u_mux (
        .clk    (pclk),
        .rst_n  (presetn),
        .sel    (sysclk_select_field == `OSS_SEL_SLOW), // [RULE1]
        .en_a   (hs_en),
        .en_b   (ls_tick),
        .en_out (sys_en_mux),
        .sel_q  (sel_slow_q)
    );

    // =================================================================
    // Watch crystal start-up
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wxt_cnt_q   <= 16'h0000;
            wxt_ready_q <= 1'b0;
        end else if (!wxt_ctrl_q[`OSS_WX_EN]) begin
            wxt_cnt_q   <= 16'h0000;
            wxt_ready_q <= 1'b0; // [RULE5]
        end else if (!wxt_ready_q && src_tick) begin
            wxt_cnt_q <= wxt_cnt_q + 16'h0001;
            // Low power mode only lengthens the wait
            if (wxt_cnt_q >= (wxt_ctrl_q[`OSS_WX_SPEEDUP] ?
                              START_FAST : START_LOWP)) begin
                wxt_ready_q <= 1'b1; // [RULE5] [RULE9]
            end
        end
    end

    // =================================================================
    // APB registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_ctrl_reg_q   <= `OSS_RST_CLK_CTRL;
            fast_rc_ctrl_reg_q <= `OSS_RST_FRC_CTRL;
            wxt_ctrl_q         <= `OSS_RST_WXT_CTRL;
            pin_ctrl_q         <= 1'b0;
        end else if (apb_wr) begin
            if (paddr == `OSS_ADDR_CLK_CTRL) begin
                clock_ctrl_reg_q <= {pwdata[7:5], 1'b0, pwdata[3:0]};
            end else if (paddr == `OSS_ADDR_FRC_CTRL) begin
                // Software must match the strap; mismatch shows in status
                fast_rc_ctrl_reg_q <= {pwdata[3:2], 1'b0,
                                       pwdata[0]}; // [RULE4]
            end else if (paddr == `OSS_ADDR_WXT_CTRL) begin
                wxt_ctrl_q[`OSS_WX_EN] <= pwdata[`OSS_WX_EN];
                if (!wxt_is_sys) begin
                    wxt_ctrl_q[`OSS_WX_SPEEDUP] <=
                        pwdata[`OSS_WX_SPEEDUP]; // [RULE6] [RULE7] [RULE8]
                end
            end else if (paddr == `OSS_ADDR_PIN_CTRL) begin
                pin_ctrl_q <= pwdata[`OSS_PIN_XTAL]; // [RULE11]
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frc_match_q <= 1'b0;
        end else begin
            frc_match_q <= (fast_rc_ctrl_reg_q[`OSS_FR_FREQ_HI:
                            `OSS_FR_FREQ_LO] == frc_option); // [RULE3]
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                if (paddr == `OSS_ADDR_CLK_CTRL) begin
                    prdata <= {24'h000000, clock_ctrl_reg_q};
                end else if (paddr == `OSS_ADDR_FRC_CTRL) begin
                    prdata <= {28'h0000000, fast_rc_ctrl_reg_q[3:2],
                               frc_s | frc_d1_q,
                               fast_rc_ctrl_reg_q[0]};
                end else if (paddr == `OSS_ADDR_WXT_CTRL) begin
                    prdata <= {29'h00000000, wxt_ctrl_q[2],
                               wxt_ready_q, wxt_ctrl_q[0]};
                end else if (paddr == `OSS_ADDR_PIN_CTRL) begin
                    prdata <= {31'h00000000, pin_ctrl_q};
                end else if (paddr == `OSS_ADDR_STATUS) begin
                    prdata <= {22'h000000, div_cnt_q,
                               !cpu_halt, wxt_is_sys,
                               frc_match_q, sel_slow_q};
                end else begin
                    pslverr <= apb_rd | pwrite;
                end
            end
        end
    end

    // =================================================================
    // Clock enables out
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_en      <= 1'b0;
            wdt_clk_en      <= 1'b0;
            tbase_clk_en    <= 1'b0;
            wxt_osc_enable  <= 1'b0;
            wxt_osc_speedup <= 1'b0;
            wxt_pins_osc    <= 1'b0;
            fast_osc_enable <= 1'b0;
        end else begin
            sys_clk_en   <= sys_en_mux && !cpu_halt; // [RULE17]
            // Watchdog stays on the slow RC even in sleep
            wdt_clk_en   <= src_tick; // [RULE12] [RULE17]
            tbase_clk_en <= ls_tick; // [RULE12]
            wxt_osc_enable  <= wxt_ctrl_q[`OSS_WX_EN] && pin_ctrl_q;
            wxt_osc_speedup <= wxt_ctrl_q[`OSS_WX_SPEEDUP]; // [RULE6]
            wxt_pins_osc    <= pin_ctrl_q; // [RULE11]
            fast_osc_enable <= !sel_slow_q ||
                               clock_ctrl_reg_q[`OSS_CC_FHIDEN];
        end
    end
endmodule // oss_top

// ===== testbench/oss_top_checker.sv
/* Port checker for oss_top.
   Assumes it is bound into oss_top, one clock, reset presetn. */
module oss_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_halt,
    input wire logic src_osc,
    input wire logic sys_clk_en,
    input wire logic wdt_clk_en,
    input wire logic tbase_clk_en,
    input wire logic wxt_osc_enable,
    input wire logic wxt_osc_speedup,
    input wire logic wxt_pins_osc
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_x = psel && penable && pready && pwrite;
    apb_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    pin_gate_a: assert property (wxt_osc_enable |-> wxt_pins_osc)
        else $error("crystal enabled while pins not routed");
    halt_stop_a: assert property (cpu_halt [*3] |-> !sys_clk_en)
        else $error("system clock runs while halted");
    sys_runt_a: assert property (sys_clk_en |=> !sys_clk_en)
        else $error("runt system clock pulse");
    wdt_tick_a: assert property ($rose(src_osc) |-> ##[1:5] wdt_clk_en)
        else $error("watchdog tick missing");
    tbase_runt_a: assert property (tbase_clk_en |=> !tbase_clk_en)
        else $error("runt time base pulse");
    // Mode only moves on a bus write; a locked write moves the enable, not the mode
    speedup_write_a: assert property ($changed(wxt_osc_speedup) |->
        $past(wr_x) || $past(wr_x, 2))
        else $error("speed-up changed without a write");
    enable_write_a: assert property ($changed(wxt_osc_enable) |->
        $past(wr_x) || $past(wr_x, 2))
        else $error("crystal enable changed without a write");
    cover property (cpu_halt && wdt_clk_en);
    cover property (wxt_osc_enable && wxt_osc_speedup);
    cover property (psel && penable && pslverr);
endmodule // oss_top_checker

bind oss_top oss_top_checker i_oss_top_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .cpu_halt(cpu_halt), .src_osc(src_osc), .sys_clk_en(sys_clk_en),
    .wdt_clk_en(wdt_clk_en), .tbase_clk_en(tbase_clk_en),
    .wxt_osc_enable(wxt_osc_enable), .wxt_osc_speedup(wxt_osc_speedup),
    .wxt_pins_osc(wxt_pins_osc));

// ===== testbench/oss_top_tb_top.sv
/* Self-checking bench for oss_top over APB.
   Assumes short start-up counts and oscillators made from pclk. */
`include "oss_defs.vh"
module oss_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, cpu_halt = 0, frc_osc = 0, fxt_osc = 0;
    logic        src_osc = 0, wxt_osc = 0, fh;
    logic [1:0]  frc_option = 2'h0;
    logic [2:0]  sl;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, r;
    logic [15:0] tk = 16'h0;
    logic [64:0] exp_q[$], ent;
    wire  [31:0] prdata;
    wire         pready, pslverr, sys_clk_en, wdt_clk_en, tbase_clk_en;
    wire         wxt_osc_enable, wxt_osc_speedup, wxt_pins_osc;
    wire         fast_osc_enable;
    int errors = 0, num_checks = 0, seed = 90, opt, s, w, t, i;
    int n_sys = 0, n_wdt = 0, n_tb = 0;
    always #12.5 pclk = ~pclk;
    oss_top #(.START_FAST(16'h0004), .START_LOWP(16'h0010)) i_oss_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frc_osc(frc_osc),
        .fxt_osc(fxt_osc), .src_osc(src_osc), .wxt_osc(wxt_osc),
        .frc_option(frc_option), .cpu_halt(cpu_halt),
        .sys_clk_en(sys_clk_en), .wdt_clk_en(wdt_clk_en),
        .tbase_clk_en(tbase_clk_en), .wxt_osc_enable(wxt_osc_enable),
        .wxt_osc_speedup(wxt_osc_speedup), .wxt_pins_osc(wxt_pins_osc),
        .fast_osc_enable(fast_osc_enable));
    // ==========================================================
    // Oscillators: periods 4, 8, 16 and 32 cycles
    always @(posedge pclk) begin
        tk <= tk + 16'h1;
        frc_osc <= tk[1];
        fxt_osc <= tk[2];
        src_osc <= tk[3];
        wxt_osc <= tk[4];
        n_sys <= n_sys + (sys_clk_en === 1'b1);
        n_wdt <= n_wdt + (wdt_clk_en === 1'b1);
        n_tb <= n_tb + (tbase_clk_en === 1'b1);
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // APB master; the expectation goes in the queue first
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] m, input logic [31:0] e, input logic er);
        exp_q.push_back({er, m, e});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0, m, e, 1'b0);
    endtask
    // Counts over a window; the sync delay makes it off by one
    task win;
        int b0, b1, b2;
        repeat (300) @(posedge pclk);
        b0 = n_sys;
        b1 = n_wdt;
        b2 = n_tb;
        repeat (768) @(posedge pclk);
        s = n_sys - b0;
        w = n_wdt - b1;
        t = n_tb - b2;
    endtask
    task near(input int seen, input int exp);
        check({31'h0, (seen - exp <= 1) && (exp - seen <= 1)}, 32'h1);
    endtask
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0)
                errors++;
            else begin
                ent = exp_q.pop_front();
                check(prdata & ent[63:32], ent[31:0]);
                check({31'h0, pslverr}, {31'h0, ent[64]});
            end
        end
    initial begin
        #(40000 * 25);
        errors++;
        stop_test;
    end
    // ==========================================================
    // Scenarios
    initial begin
        opt = {$random(seed)} % 3;
        frc_option = opt[1:0];
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OSS_ADDR_CLK_CTRL, 32'hff, 32'h00);
        check({31'h0, fast_osc_enable}, 32'h1);
        rd(`OSS_ADDR_FRC_CTRL, 32'h0d, 32'h01);
        rd(`OSS_ADDR_WXT_CTRL, 32'h05, 32'h00);
        apb(1'b0, 12'h020, 32'h0, 32'h0, 32'h0, 1'b1);
        wr(`OSS_ADDR_FRC_CTRL, {28'h0, opt[1:0] ^ 2'h1, 2'h1});
        rd(`OSS_ADDR_STATUS, 32'h2, 32'h0);
        wr(`OSS_ADDR_FRC_CTRL, {28'h0, opt[1:0], 2'h1});
        rd(`OSS_ADDR_STATUS, 32'h2, 32'h2);
        for (i = 0; i < 14; i++) begin
            sl = i % 7;
            fh = (i >= 7);
            r = $random(seed);
            // one fast and one slow source always set
            wr(`OSS_ADDR_CLK_CTRL, {24'h0, sl, 1'b0, fh, 1'b0, r[1:0]});
            win;
            near(s, (fh ? 96 : 192) >> sl);
        end
        wr(`OSS_ADDR_CLK_CTRL, 32'he0);
        win;
        near(s, 48);
        near(t, 48);
        near(w, 48);
        wr(`OSS_ADDR_PIN_CTRL, 32'h1);
        wr(`OSS_ADDR_WXT_CTRL, 32'h5);
        rd(`OSS_ADDR_WXT_CTRL, 32'h2, 32'h0);
        check({31'h0, wxt_osc_enable}, 32'h1);
        check({31'h0, wxt_osc_speedup}, 32'h1);
        repeat (150) @(posedge pclk);
        rd(`OSS_ADDR_WXT_CTRL, 32'h2, 32'h2);
        // Low power start-up takes four times as many ticks
        wr(`OSS_ADDR_WXT_CTRL, 32'h0);
        repeat (50) @(posedge pclk);
        wr(`OSS_ADDR_WXT_CTRL, 32'h1);
        repeat (150) @(posedge pclk);
        rd(`OSS_ADDR_WXT_CTRL, 32'h2, 32'h0);
        repeat (250) @(posedge pclk);
        rd(`OSS_ADDR_WXT_CTRL, 32'h2, 32'h2);
        wr(`OSS_ADDR_WXT_CTRL, 32'h5);
        wr(`OSS_ADDR_CLK_CTRL, 32'he4);
        win;
        near(s, 24);
        wr(`OSS_ADDR_WXT_CTRL, 32'h1);
        rd(`OSS_ADDR_WXT_CTRL, 32'h5, 32'h5);
        check({31'h0, wxt_osc_speedup}, 32'h1);
        wr(`OSS_ADDR_CLK_CTRL, 32'he0);
        wr(`OSS_ADDR_WXT_CTRL, 32'h1);
        rd(`OSS_ADDR_WXT_CTRL, 32'h7, 32'h3);
        check({31'h0, wxt_osc_speedup}, 32'h0);
        cpu_halt <= 1'b1;
        win;
        check(s, 0);
        near(w, 48);
        cpu_halt <= 1'b0;
        wr(`OSS_ADDR_PIN_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        check({31'h0, wxt_osc_enable}, 32'h0);
        check({31'h0, fast_osc_enable}, 32'h0);
        stop_test;
    end
endmodule // oss_top_tb_top
